// File: hw/fpe_pkg.sv
// flash program/erase sequencer: shared constants, types and timings
// assumes a single 200 MHz clock and a 32-bit apb register bus
package fpe_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned NS_PER_US     = 1000;
    localparam int unsigned T_WORD_US     = 40;     // word program time
    localparam int unsigned T_ROW_US      = 2000;   // row program time
    localparam int unsigned T_PAGE_US     = 20000;  // block erase time
    localparam int unsigned T_BULK_US     = 40000;  // bulk erase time
    localparam int unsigned WORD_CYC = T_WORD_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned ROW_CYC  = T_ROW_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned PAGE_CYC = T_PAGE_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned BULK_CYC = T_BULK_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W  = 24;
    localparam logic [TIMER_W-1:0] NONE_CYC = 24'h000001;

    // ----------------------------------------------------------------
    // register map and fields
    // ----------------------------------------------------------------
    localparam int unsigned   APB_AW     = 12;
    localparam logic [11:0]   CTRL_OFS   = 12'h000;
    localparam logic [11:0]   KEY_OFS    = 12'h004;
    localparam logic [15:0]   CTRL_RESET = 16'h0000;
    localparam int unsigned   START_BIT  = 15;
    localparam int unsigned   ENABLE_BIT = 14;
    localparam int unsigned   ERROR_BIT  = 13;
    localparam int unsigned   CLASS_BIT  = 6;
    localparam int unsigned   OP_LSB     = 0;
    localparam int unsigned   OP_W       = 4;
    localparam int unsigned   LANE_LO    = 0;
    localparam int unsigned   LANE_HI    = 1;
    localparam int unsigned   KEY_W      = 8;
    localparam logic [7:0]    KEY_FIRST  = 8'h55;
    localparam logic [7:0]    KEY_SECOND = 8'hAA;
    localparam logic [3:0]    OP_BULK    = 4'hF;
    localparam logic [3:0]    OP_WORD    = 4'h3;
    localparam logic [3:0]    OP_PAGE    = 4'h2;
    localparam logic [3:0]    OP_ROW     = 4'h1;

    // ----------------------------------------------------------------
    // flash geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W          = 24;
    localparam int unsigned ROW_ADDR_BITS   = 7;   // 64 instructions
    localparam int unsigned BLOCK_ADDR_BITS = 10;  // 512 instructions

    typedef enum logic [2:0] {
        FPE_NONE,
        FPE_WORD,
        FPE_ROW,
        FPE_PAGE,
        FPE_BULK
    } fpe_op_t;

    // command bundle towards the flash array
    typedef struct packed {
        logic              busy;
        logic              commit;
        logic              erase;
        logic              protect_set;
        fpe_op_t           op;
        logic [ADDR_W-1:0] addr;
    } fpe_cmd_t;

endpackage

// File: hw/fpe_key_unit.sv
// fpe_key_unit: tracks the two-write unlock key sequence
// assumes write pulses from the apb slave on the same clock
module fpe_key_unit
    import fpe_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             warm_rst,
    input  wire logic             key_wr,
    input  wire logic [KEY_W-1:0] key_data,
    input  wire logic             other_wr,
    input  wire logic             start_try,
    output logic                  armed,
    output logic                  broken
);

    typedef enum logic [1:0] { KEY_IDLE, KEY_HALF, KEY_ARMED } fpe_key_t;

    fpe_key_t state;
    fpe_key_t next_state;
    logic     next_broken;

    // ----------------------------------------------------------------
    // sequence decode
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_broken = 1'b0;
        case (state)
            KEY_IDLE:
            begin
                if (key_wr && key_data == KEY_FIRST)
                    next_state = KEY_HALF;
            end
            KEY_HALF:
            begin
                if (key_wr && key_data == KEY_SECOND)
                    next_state = KEY_ARMED;
                else if (key_wr || other_wr || start_try)
                begin
                    next_state  = KEY_IDLE;
                    next_broken = 1'b1;
                end
            end
            KEY_ARMED:
            begin
                if (start_try)
                    next_state = KEY_IDLE;        // arming is used up
                else if (key_wr || other_wr)
                begin
                    next_state  = KEY_IDLE;
                    next_broken = 1'b1;
                end
            end
            default:
                next_state = KEY_IDLE;
        endcase
        if (warm_rst)
            next_state = KEY_IDLE;
    end

    // state and error pulse registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state  <= KEY_IDLE;
            broken <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            broken <= next_broken;
        end
    end

    assign armed = (state == KEY_ARMED);

endmodule

// File: hw/fpe_op_timer.sv
// fpe_op_timer: self-timed countdown for one flash operation
// assumes load is a single-cycle pulse while idle
module fpe_op_timer
    import fpe_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               load,
    input  wire logic [TIMER_W-1:0] load_count,
    output logic                    busy,
    output logic                    done
);

    logic [TIMER_W-1:0] count;

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (load)
            begin
                count <= load_count;
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                if (count <= TIMER_W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count <= count - TIMER_W'(1);
            end
        end
    end

endmodule

// File: hw/fpe_ctrl.sv
// fpe_ctrl: flash program/erase control with apb register access
// assumes presetn is the power-on reset; warm_rst is a synchronous reset
// from other reset sources; target_addr and serial_mode are on pclk
//
// Contract
// - the key register is write-only and always reads as zero
// - processor stall is held for the whole program or erase operation
// - bit 15 launches the chosen operation and clears itself when done
// - software can set bit 15 but never clear it
// - each operation is timed inside the block
// - bit 14 allows program and erase; zero inhibits them
// - bit 13 flags an improper sequence; reads zero after normal end
// - bit 6 picks erase when one, program when zero
// - op codes: F bulk (serial mode only), 3 word, 2 page erase, 1 row; mismatch does nothing
// - any other op code performs no flash operation
// - control bits reset only on power-on reset
// - bits 12..7 and 5..4 read as zero
// - erasing the last page clears configuration and sets protection
// - erase covers an aligned block of 512 instructions
// - table writes only fill latches; array changes at program start
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
module fpe_ctrl
    import fpe_pkg::*;
#(
    parameter int unsigned          WORD_CYCLES    = WORD_CYC,
    parameter int unsigned          ROW_CYCLES     = ROW_CYC,
    parameter int unsigned          PAGE_CYCLES    = PAGE_CYC,
    parameter int unsigned          BULK_CYCLES    = BULK_CYC,
    parameter logic [ADDR_W-1:0]    LAST_PAGE_BASE = 24'h015400
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              warm_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              serial_mode,
    input  wire logic [ADDR_W-1:0] target_addr,
    output logic                   cpu_stall,
    output fpe_cmd_t               flash_cmd
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic               start_bit;
    logic               enable_bit;
    logic               err_bit;
    logic               class_bit;
    logic [OP_W-1:0]    op_sel;
    logic               ctrl_hit;
    logic               key_hit;
    logic               wr_acc;
    logic               ctrl_wr;
    logic               key_wr;
    logic               start_try;
    logic               other_wr;
    logic               armed;
    logic               broken;
    logic               launch;
    logic               fail;
    logic               new_enable;
    logic               new_class;
    logic [OP_W-1:0]    new_op;
    fpe_op_t            new_kind;
    fpe_op_t            run_kind;
    logic [TIMER_W-1:0] run_count;
    logic               tmr_busy;
    logic               tmr_done;
    logic [15:0]        ctrl_view;
    logic [ADDR_W-1:0]  block_base;

    // ----------------------------------------------------------------
    // operation decode
    // ----------------------------------------------------------------
    function automatic fpe_op_t decode_op(
        input logic            cls,
        input logic [OP_W-1:0] op,
        input logic            serial
    );
        fpe_op_t r;
        r = FPE_NONE;
        case (op)
            OP_BULK: if (cls && serial) r = FPE_BULK;
            OP_WORD: if (!cls) r = FPE_WORD;
            OP_PAGE: if (cls) r = FPE_PAGE;
            OP_ROW:  if (!cls) r = FPE_ROW;
            default: r = FPE_NONE;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign ctrl_hit = (paddr == CTRL_OFS);
    assign key_hit  = (paddr == KEY_OFS);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !(ctrl_hit || key_hit);
    assign wr_acc   = psel && penable && pwrite;
    assign ctrl_wr  = wr_acc && ctrl_hit && !start_bit;
    assign key_wr   = wr_acc && key_hit && pstrb[LANE_LO];

    // values that a control write would leave behind
    assign new_enable = (ctrl_wr && pstrb[LANE_HI]) ? pwdata[ENABLE_BIT]
                                                     : enable_bit;
    assign new_class  = (ctrl_wr && pstrb[LANE_LO]) ? pwdata[CLASS_BIT]
                                                     : class_bit;
    assign new_op     = (ctrl_wr && pstrb[LANE_LO])
                        ? pwdata[OP_LSB +: OP_W] : op_sel;
    assign new_kind   = decode_op(new_class, new_op, serial_mode);

    // start attempt, launch and failure
    assign start_try = ctrl_wr && pstrb[LANE_HI] && pwdata[START_BIT];
    assign other_wr  = wr_acc && !key_wr && !start_try;
    assign launch    = start_try && armed && new_enable;
    assign fail      = (start_try && !(armed && new_enable))
                       || broken;

    // ----------------------------------------------------------------
    // unlock key sequence
    // ----------------------------------------------------------------
    fpe_key_unit u_key
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .warm_rst  (warm_rst),
        .key_wr    (key_wr),
        .key_data  (pwdata[KEY_W-1:0]),
        .other_wr  (other_wr),
        .start_try (start_try),
        .armed     (armed),
        .broken    (broken)
    );

    // ----------------------------------------------------------------
    // operation timing
    // ----------------------------------------------------------------
    always_comb
    begin
        case (new_kind)
            FPE_WORD: run_count = TIMER_W'(WORD_CYCLES);
            FPE_ROW:  run_count = TIMER_W'(ROW_CYCLES);
            FPE_PAGE: run_count = TIMER_W'(PAGE_CYCLES);
            FPE_BULK: run_count = TIMER_W'(BULK_CYCLES);
            default:  run_count = NONE_CYC;
        endcase
    end

    fpe_op_timer u_timer
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (launch),
        .load_count (run_count),
        .busy       (tmr_busy),
        .done       (tmr_done)
    );

    // ----------------------------------------------------------------
    // control register, power-on reset only
    // ----------------------------------------------------------------
    // start bit: set by launch, cleared only by completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_bit <= CTRL_RESET[START_BIT];
        else if (launch)
            start_bit <= 1'b1;
        else if (tmr_done)
            start_bit <= 1'b0;
    end

    // modify enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable_bit <= CTRL_RESET[ENABLE_BIT];
        else
            enable_bit <= new_enable;
    end

    // error flag: a new error wins over any clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_bit <= CTRL_RESET[ERROR_BIT];
        else if (fail)
            err_bit <= 1'b1;
        else if (tmr_done && run_kind != FPE_NONE)
            err_bit <= 1'b0;
        else if (ctrl_wr && pstrb[LANE_HI])
            err_bit <= pwdata[ERROR_BIT];
    end

    // class bit and operation field
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            class_bit <= CTRL_RESET[CLASS_BIT];
            op_sel    <= CTRL_RESET[OP_LSB +: OP_W];
        end
        else
        begin
            class_bit <= new_class;
            op_sel    <= new_op;
        end
    end

    // ----------------------------------------------------------------
    // read path, captured in the setup phase
    // ----------------------------------------------------------------
    always_comb
    begin
        ctrl_view                    = '0;
        ctrl_view[START_BIT]         = start_bit;
        ctrl_view[ENABLE_BIT]        = enable_bit;
        ctrl_view[ERROR_BIT]         = err_bit;
        ctrl_view[CLASS_BIT]         = class_bit;
        ctrl_view[OP_LSB +: OP_W]    = op_sel;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable)
        begin
            if (ctrl_hit && !pwrite)
                prdata <= {16'h0000, ctrl_view};
            else
                prdata <= '0;
        end
    end

    // ----------------------------------------------------------------
    // stall and flash command
    // ----------------------------------------------------------------
    assign block_base = {target_addr[ADDR_W-1:BLOCK_ADDR_BITS],
                         {BLOCK_ADDR_BITS{1'b0}}};

    // processor stall follows the running operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cpu_stall <= 1'b0;
        else if (launch)
            cpu_stall <= 1'b1;
        else if (tmr_done)
            cpu_stall <= 1'b0;
    end

    // kind of the running operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_kind <= FPE_NONE;
        else if (launch)
            run_kind <= new_kind;
    end

    // command pulses and target address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_cmd <= '0;
        else
        begin
            flash_cmd.busy        <= tmr_busy || launch;
            flash_cmd.commit      <= launch && (new_kind == FPE_WORD
                                     || new_kind == FPE_ROW);
            flash_cmd.erase       <= launch && (new_kind == FPE_PAGE
                                     || new_kind == FPE_BULK);
            flash_cmd.protect_set <= launch && (new_kind == FPE_BULK
                                     || (new_kind == FPE_PAGE
                                     && block_base == LAST_PAGE_BASE));
            if (launch)
            begin
                flash_cmd.op <= new_kind;
                case (new_kind)
                    FPE_ROW:  flash_cmd.addr <= {target_addr[ADDR_W-1:
                              ROW_ADDR_BITS], {ROW_ADDR_BITS{1'b0}}};
                    FPE_PAGE: flash_cmd.addr <= block_base;
                    default:  flash_cmd.addr <= target_addr;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence launch_real_s;
        launch && new_kind != FPE_NONE;
    endsequence

    sequence launch_none_s;
        launch && new_kind == FPE_NONE;
    endsequence

    key_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && key_hit && !pwrite) |=> prdata == '0)
        else $error("key register read returned data");

    stall_held_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch_real_s |=> cpu_stall [*8])
        else $error("stall dropped during operation");

    start_sets_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch |=> start_bit && tmr_busy)
        else $error("start bit not set on launch");

    start_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(start_bit) |-> $past(tmr_done))
        else $error("start bit cleared without completion");

    timed_op_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch_real_s |=> tmr_busy [*8])
        else $error("operation ended too early");

    inhibit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (start_try && !new_enable) |=> !start_bit && err_bit)
        else $error("start accepted while inhibited");

    error_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        fail |=> err_bit)
        else $error("error flag not set");

    mismatch_none_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        launch_none_s |=> !flash_cmd.commit && !flash_cmd.erase
                          ##2 !start_bit)
        else $error("mismatched operation acted");

    unused_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        prdata[12:7] == '0 && prdata[5:4] == '0)
        else $error("unimplemented bits read nonzero");

    commit_cause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        flash_cmd.commit |-> $past(launch) && !class_bit)
        else $error("array commit without program start");

endmodule

// File: dv/tb_fpe_ctrl.sv
// testbench for fpe_ctrl: apb access, unlock key, timed operations
// assumes a zero-wait apb slave and shortened operation counts
module tb_fpe_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import fpe_pkg::*;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    localparam int WC = 12;
    localparam int RC = 14;
    localparam int PC = 16;
    localparam int BC = 18;
    logic        pclk = 1'b0;
    logic        presetn, warm_rst, psel, penable, pwrite, serial_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [23:0] target_addr;
    logic        pready, pslverr, cpu_stall, e;
    fpe_cmd_t    flash_cmd;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [15:0] cv [9] = '{16'h4042, 16'h4003, 16'h4001, 16'h404F,
        16'h404F, 16'h4043, 16'h4002, 16'h4005, 16'h4041};
    int          cy [9] = '{PC, WC, RC, BC, 1, 1, 1, 1, 1};
    logic        sm [9] = '{0, 0, 0, 1, 0, 0, 0, 0, 0};
    fpe_op_t     ko [9] = '{FPE_PAGE, FPE_WORD, FPE_ROW, FPE_BULK, FPE_NONE,
        FPE_NONE, FPE_NONE, FPE_NONE, FPE_NONE};

    fpe_ctrl #(.WORD_CYCLES(WC), .ROW_CYCLES(RC), .PAGE_CYCLES(PC),
        .BULK_CYCLES(BC)) uut (.pclk(pclk), .presetn(presetn),
        .warm_rst(warm_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .serial_mode(serial_mode), .target_addr(target_addr),
        .cpu_stall(cpu_stall), .flash_cmd(flash_cmd));

    // clock
    always #2.5 pclk = ~pclk;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        num_checks++;
        if (got !== ex)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        xfer(1'b1, a, {16'h0000, d});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [15:0] ex);
        xfer(1'b0, a, 32'h00000000);
        chk("read", {16'h0000, ex}, q);
    endtask

    task automatic kp();
        wr(KEY_OFS, 16'h0055);
        wr(KEY_OFS, 16'h00AA);
    endtask

    // keyed launch, optional clear attempt, stall length and final value
    task automatic run_op(input logic [15:0] c, input int cyc, input bit p,
                          input fpe_op_t ek);
        int         k;
        logic [2:0] pl;
        logic [2:0] xp;
        pl = '0;
        xp = {ek == FPE_BULK, ek == FPE_PAGE || ek == FPE_BULK,
              ek == FPE_WORD || ek == FPE_ROW};
        k = 0;
        wr(CTRL_OFS, c);
        kp();
        wr(CTRL_OFS, c | 16'h8000);
        // two idle cycles after the start, collecting command pulses
        repeat (2)
        begin
            @(posedge pclk);
            pl |= {flash_cmd.protect_set, flash_cmd.erase, flash_cmd.commit};
            if (cpu_stall === 1'b1)
                k++;
        end
        if (p)
        begin
            wr(CTRL_OFS, 16'h0000);
            rdc(CTRL_OFS, c | 16'h8000);
            chk("cpu_stall", 1, cpu_stall);
            k = k + 6;
        end
        for (int i = 0; i < 300; i++)
        begin
            @(posedge pclk);
            if (cpu_stall === 1'b1)
                k++;
            else if (i > 3)
                break;
        end
        chk("stall_len", 1, k >= cyc - 1 && k <= cyc + 1);
        chk("cmd_op", ek, flash_cmd.op);
        chk("cmd_pulse", xp, pl);
        rdc(CTRL_OFS, c);
    endtask

    // ----------------------------------------------------------------
    // sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        #200000;
        mismatches++;
        conclude();
    end

    initial
    begin
        {presetn, warm_rst, psel, penable, pwrite, serial_mode} = '0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        target_addr = 24'h000400;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(CTRL_OFS, 16'h0000);
        wr(CTRL_OFS, 16'hFFFF);
        rdc(CTRL_OFS, 16'h604F);
        wr(CTRL_OFS, 16'h0042);
        kp();
        wr(CTRL_OFS, 16'h8042);
        rdc(CTRL_OFS, 16'h2042);
        wr(CTRL_OFS, 16'h4042);
        wr(KEY_OFS, 16'h0055);
        wr(CTRL_OFS, 16'h4042);
        wr(KEY_OFS, 16'h00AA);
        wr(CTRL_OFS, 16'hC042);
        rdc(CTRL_OFS, 16'h6042);
        chk("cpu_stall", 0, cpu_stall);
        rdc(KEY_OFS, 16'h0000);
        for (int i = 0; i < 9; i++)
        begin
            serial_mode <= sm[i];
            run_op(cv[i], cy[i], i == 0, ko[i]);
        end
        wr(CTRL_OFS, 16'h4001);
        kp();
        warm_rst <= 1'b1;
        @(posedge pclk);
        warm_rst <= 1'b0;
        rdc(CTRL_OFS, 16'h4001);
        wr(CTRL_OFS, 16'hC001);
        rdc(CTRL_OFS, 16'h6001);
        wr(KEY_OFS, 16'h0055);
        xfer(1'b1, 12'h008, 32'h0000FFFF);
        chk("pslverr", 1, e);
        wr(KEY_OFS, 16'h00AA);
        wr(CTRL_OFS, 16'hC001);
        rdc(CTRL_OFS, 16'h6001);
        conclude();
    end
endmodule
